// >>> cbt_map.svh
// Register offsets, field positions, reset values and limits of the CAN
// bit-timing and error-state block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH

`define CBT_OFS_PRESC     8'h00
`define CBT_OFS_SEG       8'h04
`define CBT_OFS_STAT      8'h08
`define CBT_OFS_ISTAT     8'h0c
`define CBT_OFS_IMASK     8'h10

`define CBT_PRESC_W       10
`define CBT_SJW_LSB       8
`define CBT_SAM_BIT       7
`define CBT_PHASE_AFTER_SAMPLE_LEN_LSB     4
`define CBT_PHASE_BEFORE_SAMPLE_LEN_LSB     0

`define CBT_ST_CFG        7
`define CBT_ST_BUSOFF     2
`define CBT_ST_PASSIVE    1
`define CBT_ST_WARN       0
`define CBT_IRQ_W         3

`define CBT_PRESC_RST     10'h000
`define CBT_SJW_RST       2'h0
`define CBT_SAM_RST       1'h0
`define CBT_PHASE_AFTER_SAMPLE_LEN_RST     3'h0
`define CBT_PHASE_BEFORE_SAMPLE_LEN_RST     4'h0

`define CBT_TEC_BUSOFF    9'h100
`define CBT_PASSIVE_LIMIT 9'h07f
`define CBT_WARN_LIMIT    9'h060
`define CBT_PHASE_AFTER_SAMPLE_LEN_MAX     3'h6
`define CBT_PHASE_BEFORE_SAMPLE_LEN_MAX     4'hd

`endif

// >>> cbt_pkg.sv
// Types shared by the CAN bit-timing and error-state block.
// Assumes the constants header is on the include path.
`include "cbt_map.svh"

package cbt_pkg;

    typedef enum logic [1:0] {
        CBT_ACTIVE,
        CBT_PASSIVE,
        CBT_BUSOFF
    } cbt_bus_state_t;

    typedef struct packed {
        logic [`CBT_PRESC_W-1:0] prescaler;
        logic [1:0]              resync_jump_width;
        logic                    majority_vote_sel;
        logic [2:0]              phase_after_sample_len;
        logic [3:0]              phase_before_sample_len;
        cbt_bus_state_t          busState;
        logic                    busOffFlag;
        logic                    passiveFlag;
        logic                    warn;
        logic [`CBT_IRQ_W-1:0]   irqStat;
        logic [`CBT_IRQ_W-1:0]   irqMask;
        logic                    ack;
        logic [31:0]             rdat;
        logic                    irq;
        logic                    txEnable;
        logic                    rxEnable;
    } cbt_state_t;

endpackage : cbt_pkg

// >>> cbt_quantum_gen.sv
// Time-quantum and nominal bit-time generator.
// Assumes its settings stay still while run is high.
`timescale 1ns/1ps
`include "cbt_map.svh"

module cbt_quantum_gen #(
    parameter int PRESC_W = `CBT_PRESC_W
) (
    input  logic               clk_sys,              // System clock
    input  logic               nrst,                 // Async reset, low
    input  logic               run,                  // Bit timing enabled
    input  logic [PRESC_W-1:0] prescaler,            // Quantum divider
    input  logic [3:0]         beforeCode,           // Segment 1 code
    input  logic [2:0]         afterCode,            // Segment 2 code
    input  logic [1:0]         sjwCode,              // Jump width code
    input  logic               samCode,              // Sampling select
    output logic               tqTick,               // Quantum end pulse
    output logic               bitStart,             // Sync quantum pulse
    output logic               samplePoint,          // Sample point pulse
    output logic [3:0]         phaseBeforeSampleLen, // Quanta before
    output logic [2:0]         phaseAfterSampleLen,  // Quanta after
    output logic [2:0]         resyncJumpWidth,      // Jump quanta
    output logic               majorityVoteSel       // Triple sampling
);

    if (PRESC_W < 1 || PRESC_W > 16) begin : g_bad_width
        $error("cbt_quantum_gen: PRESC_W must be 1 to 16");
    end

    typedef struct packed {
        logic [PRESC_W-1:0] preCnt;
        logic [4:0]         tqCnt;
        logic               tick;
        logic               bitStart;
        logic               sample;
        logic [3:0]         beforeLen;
        logic [2:0]         afterLen;
        logic [2:0]         sjwLen;
        logic               majority_vote_sel;
    } cbt_qgen_t;

    cbt_qgen_t s;
    cbt_qgen_t next_s;
    logic [4:0] lastIdx;
    logic [4:0] sampleIdx;

    always_comb begin
        next_s          = s;
        next_s.tick     = 1'b0;
        next_s.bitStart = 1'b0;
        next_s.sample   = 1'b0;
        lastIdx   = 5'(beforeCode) + 5'(afterCode) + 5'h02;
        sampleIdx = 5'(beforeCode) + 5'h02;
        next_s.beforeLen = beforeCode + 4'h1;
        next_s.afterLen  = afterCode + 3'h1;
        next_s.sjwLen    = 3'(sjwCode) + 3'h1;
        next_s.majority_vote_sel       = samCode;
        if (!run) begin
            next_s.preCnt = '0;
            next_s.tqCnt  = 5'h00;
        end else if (s.preCnt == prescaler) begin
            next_s.preCnt = '0;
            next_s.tick   = 1'b1;
            if (s.tqCnt == lastIdx) begin
                next_s.tqCnt    = 5'h00;
                next_s.bitStart = 1'b1;
            end else begin
                next_s.tqCnt  = s.tqCnt + 5'h01;
                next_s.sample = (s.tqCnt + 5'h01) == sampleIdx;
            end
        end else begin
            next_s.preCnt = s.preCnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tqTick               = s.tick;
    assign bitStart             = s.bitStart;
    assign samplePoint          = s.sample;
    assign phaseBeforeSampleLen = s.beforeLen;
    assign phaseAfterSampleLen  = s.afterLen;
    assign resyncJumpWidth      = s.sjwLen;
    assign majorityVoteSel      = s.majority_vote_sel;

    // Helper counters that only the checks below read.
    localparam int GW = PRESC_W + 1;
    logic [GW-1:0] gapCnt;
    logic          seenTick;
    logic [4:0]    ticksSinceBit;
    logic          seenBit;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gapCnt        <= '0;
            seenTick      <= 1'b0;
            ticksSinceBit <= 5'h00;
            seenBit       <= 1'b0;
        end else begin
            gapCnt   <= s.tick ? GW'(1) : gapCnt + 1'b1;
            seenTick <= run && (seenTick || s.tick);
            seenBit  <= run && (seenBit || s.bitStart);
            if (s.bitStart) begin
                ticksSinceBit <= 5'h00;
            end else if (s.tick) begin
                ticksSinceBit <= ticksSinceBit + 5'h01;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_quantum_period: assert property (
        s.tick && seenTick && run |-> gapCnt == GW'(prescaler) + 1'b1)
        else $error("quantum length is not prescaler plus one");
    chk_bit_length: assert property (
        s.bitStart && seenBit && run |-> ticksSinceBit == lastIdx)
        else $error("nominal bit has wrong number of quanta");
    chk_sample_place: assert property (
        s.sample && seenBit && run |-> ticksSinceBit == sampleIdx - 5'h01)
        else $error("sample point not after sync and first segment");
    chk_stop_idle: assert property (
        !run ##1 !run |-> !s.tick)
        else $error("quantum tick while timing is stopped");
    cov_sample_triple: cover property (s.sample && s.majority_vote_sel);

endmodule : cbt_quantum_gen

// >>> cbt_error_state.sv
// CAN error-state status, bit-timing registers and interrupt flags, with a
// classic Wishbone slave.
// Assumes the frame engine supplies the error counters, the bus-off
// recovery pulse and the configuration-mode level, all on clk_sys.
//
// Overview of operation
// - Transmit error count 256 enters bus-off.
// - Bus-off stops transmitting and receiving.
// - Counter values ignored by the bus state while bus-off; warning flag still follows them.
// - Recovery returns to bus-on, clears flag.
// - Error-passive flag mirrors error-passive mode.
// - Warning flag when either counter exceeds 96.
// - Ten-bit prescaler field, values 0 to 1023.
// - Jump width code plus one quanta.
// - Sampling select: single or triple sampling.
// - After-sample segment code plus one quanta.
// - Before-sample segment code plus one quanta.
// - Timing registers writable only in configuration.
`timescale 1ns/1ps
`include "cbt_map.svh"

module cbt_error_state
    import cbt_pkg::*;
(
    input  logic        clk_sys,              // System clock, 100 MHz
    input  logic        nrst,                 // Async reset, active low
    input  logic        wb_cyc_i,             // Wishbone cycle
    input  logic        wb_stb_i,             // Wishbone strobe
    input  logic        wb_we_i,              // Wishbone write enable
    input  logic [7:0]  wb_adr_i,             // Wishbone byte address
    input  logic [3:0]  wb_sel_i,             // Wishbone byte lanes
    input  logic [31:0] wb_dat_i,             // Wishbone write data
    output logic [31:0] wb_dat_o,             // Wishbone read data
    output logic        wb_ack_o,             // Wishbone acknowledge
    input  logic [8:0]  txErrCount,           // Transmit error counter
    input  logic [7:0]  rxErrCount,           // Receive error counter
    input  logic        busOffRecovered,      // Recovery done pulse
    input  logic        configModeFlag,       // Configuration mode
    output logic        busOffFlag,           // Bus-off state
    output logic        errorPassiveFlag,     // Error-passive state
    output logic        warningFlag,          // Warning level
    output logic        txEnable,             // Transmission allowed
    output logic        rxEnable,             // Reception allowed
    output logic        irq,                  // Level interrupt
    output logic        tqTick,               // Quantum end pulse
    output logic        bitStart,             // Sync quantum pulse
    output logic        samplePoint,          // Sample point pulse
    output logic [3:0]  phaseBeforeSampleLen, // Quanta before sample
    output logic [2:0]  phaseAfterSampleLen,  // Quanta after sample
    output logic [2:0]  resyncJumpWidth,      // Jump width in quanta
    output logic        majorityVoteSel       // Triple sampling on
);

    localparam logic [3:0] LANE0 = 4'h1;

    cbt_state_t s;
    cbt_state_t next_s;
    logic       access;
    logic       wr;
    logic [31:0] merged;
    logic [`CBT_IRQ_W-1:0] events;
    logic [`CBT_IRQ_W-1:0] clears;
    logic [31:0] prescWord;
    logic [31:0] segWord;

    function automatic logic [31:0] applyLanes(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  sel
    );
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return m;
    endfunction : applyLanes

    function automatic logic hits(
        input logic [7:0] adr,
        input logic [7:0] ofs
    );
        return {adr[7:2], 2'b00} == ofs;
    endfunction : hits

    always_comb begin
        next_s = s;
        merged = 32'h0000_0000;
        access = wb_cyc_i && wb_stb_i && !s.ack;
        wr     = access && wb_we_i;
        next_s.ack = access;

        prescWord = 32'(s.prescaler);
        segWord   = 32'({s.resync_jump_width, s.majority_vote_sel, s.phase_after_sample_len, s.phase_before_sample_len});

        case (s.busState)
            CBT_ACTIVE, CBT_PASSIVE: begin
                if (txErrCount >= `CBT_TEC_BUSOFF) begin
                    next_s.busState = CBT_BUSOFF;
                end else if (txErrCount > `CBT_PASSIVE_LIMIT ||
                             {1'b0, rxErrCount} > `CBT_PASSIVE_LIMIT) begin
                    next_s.busState = CBT_PASSIVE;
                end else begin
                    next_s.busState = CBT_ACTIVE;
                end
            end
            CBT_BUSOFF: begin
                // The counters are not trusted here; only the recovery
                // pulse from the frame engine ends bus-off.
                if (busOffRecovered) begin
                    next_s.busState = CBT_ACTIVE;
                end
            end
            default: begin
                next_s.busState = CBT_BUSOFF;
            end
        endcase

        next_s.busOffFlag  = next_s.busState == CBT_BUSOFF;
        next_s.passiveFlag = next_s.busState == CBT_PASSIVE;
        next_s.warn = txErrCount > `CBT_WARN_LIMIT ||
                      {1'b0, rxErrCount} > `CBT_WARN_LIMIT;
        next_s.txEnable = !next_s.busOffFlag && !configModeFlag;
        next_s.rxEnable = !next_s.busOffFlag && !configModeFlag;

        events[`CBT_ST_BUSOFF]  = next_s.busOffFlag && !s.busOffFlag;
        events[`CBT_ST_PASSIVE] = next_s.passiveFlag && !s.passiveFlag;
        events[`CBT_ST_WARN]    = next_s.warn && !s.warn;
        clears = '0;

        if (wr) begin
            if (hits(wb_adr_i, `CBT_OFS_PRESC) && configModeFlag) begin
                merged = applyLanes(prescWord, wb_dat_i, wb_sel_i);
                next_s.prescaler = merged[`CBT_PRESC_W-1:0];
            end
            if (hits(wb_adr_i, `CBT_OFS_SEG) && configModeFlag) begin
                merged = applyLanes(segWord, wb_dat_i, wb_sel_i);
                // A write carrying a reserved segment code is dropped
                // whole; only the reset code 0 in both segments reaches the generator as a reserved code.
                if (merged[`CBT_PHASE_AFTER_SAMPLE_LEN_LSB +: 3] != 3'h0 &&
                    merged[`CBT_PHASE_AFTER_SAMPLE_LEN_LSB +: 3] <= `CBT_PHASE_AFTER_SAMPLE_LEN_MAX &&
                    merged[`CBT_PHASE_BEFORE_SAMPLE_LEN_LSB +: 4] != 4'h0 &&
                    merged[`CBT_PHASE_BEFORE_SAMPLE_LEN_LSB +: 4] <= `CBT_PHASE_BEFORE_SAMPLE_LEN_MAX) begin
                    next_s.resync_jump_width   = merged[`CBT_SJW_LSB +: 2];
                    next_s.majority_vote_sel   = merged[`CBT_SAM_BIT];
                    next_s.phase_after_sample_len = merged[`CBT_PHASE_AFTER_SAMPLE_LEN_LSB +: 3];
                    next_s.phase_before_sample_len = merged[`CBT_PHASE_BEFORE_SAMPLE_LEN_LSB +: 4];
                end
            end
            if (hits(wb_adr_i, `CBT_OFS_ISTAT) && (wb_sel_i & LANE0) != 0)
            begin
                clears = wb_dat_i[`CBT_IRQ_W-1:0];
            end
            if (hits(wb_adr_i, `CBT_OFS_IMASK)) begin
                merged = applyLanes(32'(s.irqMask), wb_dat_i, wb_sel_i);
                next_s.irqMask = merged[`CBT_IRQ_W-1:0];
            end
        end

        // A new event beats a clear written in the same cycle.
        next_s.irqStat = (s.irqStat & ~clears) | events;
        next_s.irq     = |(next_s.irqStat & next_s.irqMask);

        next_s.rdat = 32'h0000_0000;
        if (access && !wb_we_i) begin
            if (hits(wb_adr_i, `CBT_OFS_PRESC)) begin
                next_s.rdat = prescWord;
            end else if (hits(wb_adr_i, `CBT_OFS_SEG)) begin
                next_s.rdat = segWord;
            end else if (hits(wb_adr_i, `CBT_OFS_STAT)) begin
                next_s.rdat[`CBT_ST_CFG]     = configModeFlag;
                next_s.rdat[`CBT_ST_BUSOFF]  = s.busOffFlag;
                next_s.rdat[`CBT_ST_PASSIVE] = s.passiveFlag;
                next_s.rdat[`CBT_ST_WARN]    = s.warn;
            end else if (hits(wb_adr_i, `CBT_OFS_ISTAT)) begin
                next_s.rdat = 32'(s.irqStat);
            end else if (hits(wb_adr_i, `CBT_OFS_IMASK)) begin
                next_s.rdat = 32'(s.irqMask);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s           <= '0;
            s.prescaler <= `CBT_PRESC_RST;
            s.resync_jump_width       <= `CBT_SJW_RST;
            s.majority_vote_sel       <= `CBT_SAM_RST;
            s.phase_after_sample_len     <= `CBT_PHASE_AFTER_SAMPLE_LEN_RST;
            s.phase_before_sample_len     <= `CBT_PHASE_BEFORE_SAMPLE_LEN_RST;
            s.busState  <= CBT_ACTIVE;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o         = s.rdat;
    assign wb_ack_o         = s.ack;
    assign busOffFlag       = s.busOffFlag;
    assign errorPassiveFlag = s.passiveFlag;
    assign warningFlag      = s.warn;
    assign txEnable         = s.txEnable;
    assign rxEnable         = s.rxEnable;
    assign irq              = s.irq;

    // Timing stops in bus-off and in configuration so that new settings
    // take hold from a clean bit boundary.
    cbt_quantum_gen #(
        .PRESC_W (`CBT_PRESC_W)
    ) u_qgen (
        .clk_sys              (clk_sys),
        .nrst                 (nrst),
        .run                  (s.txEnable),
        .prescaler            (s.prescaler),
        .beforeCode           (s.phase_before_sample_len),
        .afterCode            (s.phase_after_sample_len),
        .sjwCode              (s.resync_jump_width),
        .samCode              (s.majority_vote_sel),
        .tqTick               (tqTick),
        .bitStart             (bitStart),
        .samplePoint          (samplePoint),
        .phaseBeforeSampleLen (phaseBeforeSampleLen),
        .phaseAfterSampleLen  (phaseAfterSampleLen),
        .resyncJumpWidth      (resyncJumpWidth),
        .majorityVoteSel      (majorityVoteSel)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_busoff_entry: assert property (
        txErrCount >= `CBT_TEC_BUSOFF && !(busOffFlag && busOffRecovered)
        |=> busOffFlag)
        else $error("bus-off not entered at transmit count 256");
    chk_busoff_silent: assert property (
        busOffFlag |-> !txEnable && !rxEnable ##1 (busOffFlag || !tqTick))
        else $error("traffic allowed while bus-off");
    chk_busoff_holds: assert property (
        busOffFlag && !busOffRecovered |=> busOffFlag)
        else $error("bus-off left without recovery");
    chk_recovery_bus_on: assert property (
        busOffFlag && busOffRecovered |=>
        !busOffFlag && txEnable == !$past(configModeFlag))
        else $error("recovery did not return to bus-on");
    chk_passive_flag: assert property (
        !busOffFlag && txErrCount > `CBT_PASSIVE_LIMIT &&
        txErrCount < `CBT_TEC_BUSOFF |=> errorPassiveFlag && !busOffFlag)
        else $error("error-passive flag missing");
    chk_passive_clear: assert property (
        txErrCount <= `CBT_PASSIVE_LIMIT &&
        {1'b0, rxErrCount} <= `CBT_PASSIVE_LIMIT |=> !errorPassiveFlag)
        else $error("error-passive flag without cause");
    chk_warn_high: assert property (
        {1'b0, rxErrCount} > `CBT_WARN_LIMIT |=> warningFlag)
        else $error("warning flag missing above 96");
    chk_warn_tx: assert property (
        txErrCount > `CBT_WARN_LIMIT |=> warningFlag)
        else $error("warning flag missing for transmit count");
    chk_warn_low: assert property (
        txErrCount <= `CBT_WARN_LIMIT &&
        {1'b0, rxErrCount} <= `CBT_WARN_LIMIT |=> !warningFlag)
        else $error("warning flag set at 96 or below");
    chk_timing_locked: assert property (
        wr && !configModeFlag |=>
        $stable(s.prescaler) && $stable(s.phase_before_sample_len) && $stable(s.resync_jump_width) &&
        $stable(s.phase_after_sample_len) && $stable(s.majority_vote_sel))
        else $error("timing changed outside configuration mode");
    chk_presc_store: assert property (
        wr && configModeFlag && hits(wb_adr_i, `CBT_OFS_PRESC) &&
        wb_sel_i == 4'hf |=> s.prescaler == $past(wb_dat_i[9:0]))
        else $error("prescaler write not stored");
    chk_unused_zero: assert property (
        access && !wb_we_i && (hits(wb_adr_i, `CBT_OFS_PRESC) ||
        hits(wb_adr_i, `CBT_OFS_SEG)) |=> wb_ack_o && wb_dat_o[31:10] == 0)
        else $error("unused timing bits read nonzero");
    chk_set_wins: assert property (
        wr && hits(wb_adr_i, `CBT_OFS_ISTAT) && events[`CBT_ST_BUSOFF]
        |=> s.irqStat[`CBT_ST_BUSOFF])
        else $error("event lost against clear");
    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");

    cov_busoff_entry: cover property (!busOffFlag ##1 busOffFlag);
    cov_recovery: cover property (busOffFlag ##1 !busOffFlag);
    cov_irq_raised: cover property (!irq ##1 irq);
    cov_timing_write: cover property (
        wr && configModeFlag && hits(wb_adr_i, `CBT_OFS_SEG));

endmodule : cbt_error_state

// >>> cbt_engine_model.sv
// Behavioural model of the frame engine that feeds the error-state block.
// Assumes the bench calls its tasks just after a rising clk_sys edge.
`timescale 1ns/1ps

module cbt_engine_model (
    input  logic       clk_sys,         // System clock
    output logic [8:0] txErrCount,      // Transmit error counter
    output logic [7:0] rxErrCount,      // Receive error counter
    output logic       busOffRecovered, // Recovery done pulse
    output logic       configModeFlag   // Configuration mode level
);
    // Starts in configuration mode so software may set the timing first.
    initial begin
        txErrCount = 9'h000;
        rxErrCount = 8'h00;
        busOffRecovered = 1'b0;
        configModeFlag = 1'b1;
    end

    task automatic set_counts(input logic [8:0] tx, input logic [7:0] rx);
        txErrCount <= tx;
        rxErrCount <= rx;
    endtask : set_counts

    task automatic set_config(input logic c);
        configModeFlag <= c;
    endtask : set_config

    // The recovery sequence ends with a single-cycle pulse.
    task automatic recover();
        busOffRecovered <= 1'b1;
        @(posedge clk_sys);
        busOffRecovered <= 1'b0;
    endtask : recover
endmodule : cbt_engine_model

// >>> tb_cbt_error_state.sv
// Self-checking bench for the CAN error-state and bit-timing block.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end

module tb_cbt_error_state;
    logic        clk_sys, nrst, wbCyc, wbStb, wbWe, busOffFlag, irq, tqTick;
    logic        errorPassiveFlag, warningFlag, txEnable, rxEnable, wbAck;
    logic        bitStart, samplePoint, majorityVoteSel, busOffRecovered;
    logic        configModeFlag;
    logic [7:0]  wbAdr, rxErrCount;
    logic [3:0]  wbSel, phaseBeforeSampleLen;
    logic [31:0] wbDatW, wbDatR, rd;
    logic [8:0]  txErrCount;
    logic [2:0]  phaseAfterSampleLen, resyncJumpWidth;
    int          fails = 0, checks = 0, n;

    cbt_error_state dut_u (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .txErrCount(txErrCount), .rxErrCount(rxErrCount),
        .busOffRecovered(busOffRecovered), .configModeFlag(configModeFlag),
        .busOffFlag(busOffFlag), .errorPassiveFlag(errorPassiveFlag),
        .warningFlag(warningFlag), .txEnable(txEnable), .rxEnable(rxEnable),
        .irq(irq), .tqTick(tqTick), .bitStart(bitStart),
        .samplePoint(samplePoint),
        .phaseBeforeSampleLen(phaseBeforeSampleLen),
        .phaseAfterSampleLen(phaseAfterSampleLen),
        .resyncJumpWidth(resyncJumpWidth), .majorityVoteSel(majorityVoteSel));

    cbt_engine_model eng_u (.clk_sys(clk_sys), .txErrCount(txErrCount),
        .rxErrCount(rxErrCount), .busOffRecovered(busOffRecovered),
        .configModeFlag(configModeFlag));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // Classic single cycle; the request holds until ack is sampled high.
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we;
        wbAdr <= a; wbDatW <= d; wbSel <= 4'hf;
        do begin
            @(posedge clk_sys);
        end while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
        @(posedge clk_sys);
    endtask : wb

    task automatic waitc(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : waitc

    function automatic logic pick(input int s);
        return (s == 0) ? tqTick : ((s == 1) ? bitStart : samplePoint);
    endfunction : pick

    // Cycles until the chosen pulse is next seen, bounded.
    task automatic gap(input int s, output int c);
        c = 0;
        do begin
            @(posedge clk_sys);
            c++;
        end while (pick(s) !== 1'b1 && c < 100);
    endtask : gap

    initial begin
        #200000;
        fails++;
        end_sim();
    end

    initial begin
        nrst = 1'b0; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0;
        wbAdr = 8'h00; wbSel = 4'h0; wbDatW = 32'h0000_0000;
        waitc(4);
        nrst <= 1'b1;
        waitc(2);
        wb(0, 8'h00, 0, rd); `CHK(rd, 32'h0000_0000)
        wb(0, 8'h04, 0, rd); `CHK(rd, 32'h0000_0000)
        wb(0, 8'h14, 0, rd); `CHK(rd, 32'h0000_0000)
        eng_u.set_config(0); waitc(2);
        wb(1, 8'h00, 5, rd); wb(0, 8'h00, 0, rd); `CHK(rd, 32'h0)
        eng_u.set_config(1); waitc(2);
        wb(1, 8'h00, 32'hffff_ffff, rd);
        wb(0, 8'h00, 0, rd); `CHK(rd, 32'h0000_03ff)
        wb(1, 8'h04, 32'h11, rd);
        wb(1, 8'h04, 32'h01, rd); wb(0, 8'h04, 0, rd);
        `CHK(rd, 32'h11)
        wb(1, 8'h04, 32'h1e, rd); wb(0, 8'h04, 0, rd);
        `CHK(rd, 32'h11)
        for (int i = 0; i < 4; i++) begin
            wb(1, 8'h04, 32'hffff_fc00 | (i << 8) | ((i & 1) << 7)
               | ((i + 3) << 4) | (4 * i + 1), rd);
            waitc(2);
            `CHK(resyncJumpWidth, 3'(i + 1))
            `CHK(majorityVoteSel, 1'(i & 1))
            `CHK(phaseAfterSampleLen, 3'(i + 4))
            `CHK(phaseBeforeSampleLen, 4'(4 * i + 2))
            wb(0, 8'h04, 0, rd);
            n = (i << 8) | ((i & 1) << 7) | ((i + 3) << 4) | (4 * i + 1);
            `CHK(rd, 32'(n))
        end
        wb(1, 8'h00, 32'h2, rd);
        wb(1, 8'h04, 32'h11, rd);
        eng_u.set_config(0);
        gap(1, n);
        gap(2, n); `CHK(n, 9)
        gap(1, n); `CHK(n, 6)
        gap(0, n); `CHK(n, 3)
        eng_u.set_counts(9'd97, 8'd0); waitc(3);
        `CHK(warningFlag, 1'b1)
        eng_u.set_counts(9'd96, 8'd96); waitc(3);
        `CHK(warningFlag, 1'b0)
        eng_u.set_counts(9'd0, 8'd97); waitc(3);
        `CHK(warningFlag, 1'b1)
        eng_u.set_counts(9'd128, 8'd0); waitc(3);
        `CHK(errorPassiveFlag, 1'b1)
        eng_u.set_counts(9'd127, 8'd0); waitc(3);
        `CHK(errorPassiveFlag, 1'b0)
        wb(1, 8'h0c, 32'h7, rd);
        wb(1, 8'h10, 32'h4, rd);
        eng_u.set_counts(9'd256, 8'd0); waitc(3);
        `CHK(busOffFlag, 1'b1)
        `CHK({txEnable, rxEnable, tqTick}, 3'b000)
        `CHK(irq, 1'b1)
        wb(0, 8'h08, 0, rd); `CHK(rd, 32'h0000_0005)
        eng_u.set_counts(9'd0, 8'd0); waitc(3); `CHK(busOffFlag, 1'b1)
        wb(1, 8'h10, 32'h0, rd); waitc(1); `CHK(irq, 1'b0)
        wb(1, 8'h10, 32'h4, rd); waitc(1); `CHK(irq, 1'b1)
        wb(1, 8'h0c, 32'h4, rd); waitc(1); `CHK(irq, 1'b0)
        eng_u.recover(); waitc(2);
        `CHK(busOffFlag, 1'b0)
        `CHK(txEnable, 1'b1)
        end_sim();
    end
endmodule : tb_cbt_error_state
